// ===== common/touch_cfg_pkg.sv
// constants for the touch scan pacing and preprocessor configuration block
package touch_cfg_pkg;

	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_SCAN_CFG = 8'h00;
	localparam logic [7:0] ADDR_PREP_CFG = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_THR_LOW = 8'h10;
	localparam logic [7:0] ADDR_THR_HIGH = 8'h14;
	localparam logic [7:0] ADDR_AUX_DATA = 8'h18;
	localparam logic [7:0] ADDR_TEMP_DATA = 8'h1c;

	// ---------------------------------------------------------------
	// field layouts and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] SCAN_CFG_RESET = 16'h0000;
	localparam logic [15:0] PREP_CFG_RESET = 16'h0000;
	localparam logic [15:0] SCAN_CFG_MASK = 16'h0f07;
	localparam logic [15:0] PREP_CFG_MASK = 16'hffdf;
	localparam int TEST_MODE_LSB = 8;
	localparam int BATCH_LSB = 0;
	localparam int PIN_SEL_LSB = 14;
	localparam int FILT_COUNT_LSB = 12;
	localparam int FILT_WIN_LSB = 10;
	localparam int TEMP_ZONE_LSB = 8;
	localparam int AUX_ZONE_LSB = 6;
	localparam int AVG_EN_LSB = 0;
	localparam int CTRL_PEN_MODE_BIT = 15;
	localparam int CTRL_STOP_BIT = 14;
	localparam logic [3:0] FUNC_RESET = 4'h0;
	localparam logic [11:0] THR_RESET = 12'h000;
	localparam logic [11:0] DATA_RESET = 12'h000;
	localparam logic [3:0] FUNC_SCAN_XYZ = 4'h0;
	localparam logic [3:0] FUNC_SCAN_XY = 4'h1;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int MS_IN_US = 1000;
	localparam int MS_CYCLES = CLK_MHZ * MS_IN_US;
	localparam logic [6:0] BATCH_MS_0 = 7'd0;
	localparam logic [6:0] BATCH_MS_1 = 7'd1;
	localparam logic [6:0] BATCH_MS_2 = 7'd2;
	localparam logic [6:0] BATCH_MS_3 = 7'd4;
	localparam logic [6:0] BATCH_MS_4 = 7'd10;
	localparam logic [6:0] BATCH_MS_5 = 7'd20;
	localparam logic [6:0] BATCH_MS_6 = 7'd40;
	localparam logic [6:0] BATCH_MS_7 = 7'd100;

	typedef enum logic [1:0] {SCAN_IDLE, SCAN_RUN, SCAN_WAIT} scan_state_e;

endpackage

// ===== hw/touch_scan_cfg.sv
// batch-paced scan scheduler, zone detection and configuration registers over apb
`timescale 1ns/1ns
`default_nettype none

module touch_scan_cfg #(
	parameter int MS_CYCLES_P = touch_cfg_pkg::MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pen_touch_n,
	input wire logic set_done,
	input wire logic filter_busy,
	input wire logic aux_valid,
	input wire logic [11:0] aux_result,
	input wire logic temp_valid,
	input wire logic [11:0] temp_result,
	output logic scan_start,
	output logic scan_active,
	output logic touch_or_data_irq_pin,
	output logic [3:0] panel_test_mode,
	output logic [2:0] batch_delay_select,
	output logic [1:0] filter_sample_count,
	output logic [1:0] filter_window,
	output logic [4:0] avg_filter_enable
);
	import touch_cfg_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [6:0] batch_ms(input logic [2:0] code);
		case (code)
			3'h0: batch_ms = BATCH_MS_0;
			3'h1: batch_ms = BATCH_MS_1;
			3'h2: batch_ms = BATCH_MS_2;
			3'h3: batch_ms = BATCH_MS_3;
			3'h4: batch_ms = BATCH_MS_4;
			3'h5: batch_ms = BATCH_MS_5;
			3'h6: batch_ms = BATCH_MS_6;
			default: batch_ms = BATCH_MS_7;
		endcase
	endfunction

	function automatic logic zone_ok(input logic [1:0] sel, input logic [11:0] val,
			input logic [11:0] lo, input logic [11:0] hi);
		case (sel)
			2'h1: zone_ok = val < lo;
			2'h2: zone_ok = (val >= lo) && (val <= hi);
			2'h3: zone_ok = val > hi;
			default: zone_ok = 1'b1;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// registers and state
	// ---------------------------------------------------------------
	logic [15:0] scan_cfg_reg;
	logic [15:0] prep_cfg_reg;
	logic pen_mode_reg;
	logic [3:0] func_reg;
	logic [11:0] thr_low_reg;
	logic [11:0] thr_high_reg;
	logic [11:0] aux_data_reg;
	logic [11:0] temp_data_reg;
	logic aux_avail_reg;
	logic temp_avail_reg;
	logic pen_meta_reg;
	logic pen_sync_n_reg;
	scan_state_e state_reg;
	logic [31:0] div_reg;
	logic [6:0] ms_left_reg;
	logic [31:0] rdata_next;
	logic addr_ok;
	logic access;
	logic wr_done;
	logic rd_done;
	logic touched;
	logic scan_func;
	logic ctrl_wr;
	logic stop_req;
	logic host_launch;
	logic dev_launch;
	logic delay_over;
	logic launch;
	logic busy;
	logic dav_any;

	assign access = psel && penable && !pready;
	assign wr_done = psel && penable && pready && pwrite && !pslverr;
	assign rd_done = psel && penable && pready && !pwrite && !pslverr;
	assign touched = !pen_sync_n_reg;
	assign scan_func = (func_reg == FUNC_SCAN_XYZ) || (func_reg == FUNC_SCAN_XY);
	assign ctrl_wr = wr_done && (paddr == ADDR_CTRL);
	assign stop_req = ctrl_wr && pwdata[CTRL_STOP_BIT];
	assign delay_over = (ms_left_reg == 7'd0);
	assign busy = (state_reg == SCAN_RUN) || filter_busy;
	assign dav_any = aux_avail_reg || temp_avail_reg;

	// ---------------------------------------------------------------
	// pen input synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pen_meta_reg <= 1'b1;
			pen_sync_n_reg <= 1'b1;
		end else begin
			pen_meta_reg <= pen_touch_n;
			pen_sync_n_reg <= pen_meta_reg;
		end
	end

	// ---------------------------------------------------------------
	// apb slave: one wait state, then answer
	// ---------------------------------------------------------------
	always_comb begin
		addr_ok = 1'b1;
		rdata_next = 32'h0000_0000;
		case (paddr)
			ADDR_SCAN_CFG: rdata_next[15:0] = scan_cfg_reg & SCAN_CFG_MASK;
			ADDR_PREP_CFG: rdata_next[15:0] = prep_cfg_reg & PREP_CFG_MASK;
			ADDR_CTRL: begin
				rdata_next[CTRL_PEN_MODE_BIT] = touched;
				rdata_next[CTRL_STOP_BIT] = !busy;
				rdata_next[3:0] = func_reg;
			end
			ADDR_STATUS: begin
				rdata_next[0] = aux_avail_reg && !filter_busy;
				rdata_next[1] = temp_avail_reg && !filter_busy;
				rdata_next[2] = !busy;
				rdata_next[3] = touched;
			end
			ADDR_THR_LOW: rdata_next[11:0] = thr_low_reg;
			ADDR_THR_HIGH: rdata_next[11:0] = thr_high_reg;
			ADDR_AUX_DATA: rdata_next[11:0] = aux_data_reg;
			ADDR_TEMP_DATA: rdata_next[11:0] = temp_data_reg;
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access && !addr_ok;
			if (access) begin
				prdata <= rdata_next;
			end
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			scan_cfg_reg <= SCAN_CFG_RESET;
			prep_cfg_reg <= PREP_CFG_RESET;
			pen_mode_reg <= 1'b0;
			func_reg <= FUNC_RESET;
			thr_low_reg <= THR_RESET;
			thr_high_reg <= THR_RESET;
		end else if (wr_done) begin
			case (paddr)
				ADDR_SCAN_CFG: scan_cfg_reg <= pwdata[15:0] & SCAN_CFG_MASK;
				ADDR_PREP_CFG: prep_cfg_reg <= pwdata[15:0] & PREP_CFG_MASK;
				ADDR_CTRL: begin
					pen_mode_reg <= pwdata[CTRL_PEN_MODE_BIT];
					func_reg <= pwdata[3:0];
				end
				ADDR_THR_LOW: thr_low_reg <= pwdata[11:0];
				ADDR_THR_HIGH: thr_high_reg <= pwdata[11:0];
				default: ;
			endcase
		end
	end

	assign panel_test_mode = scan_cfg_reg[TEST_MODE_LSB +: 4];
	assign batch_delay_select = scan_cfg_reg[BATCH_LSB +: 3];
	assign filter_sample_count = prep_cfg_reg[FILT_COUNT_LSB +: 2];
	assign filter_window = prep_cfg_reg[FILT_WIN_LSB +: 2];
	assign avg_filter_enable = prep_cfg_reg[AVG_EN_LSB +: 5];

	// ---------------------------------------------------------------
	// batch delay timer
	// ---------------------------------------------------------------
	// device scan armed by mode, code and pen touch
	assign dev_launch = pen_mode_reg && scan_func && touched;
	assign host_launch = ctrl_wr && !pwdata[CTRL_PEN_MODE_BIT] && !pwdata[CTRL_STOP_BIT]
		&& ((pwdata[3:0] == FUNC_SCAN_XYZ) || (pwdata[3:0] == FUNC_SCAN_XY)) && touched;
	assign launch = (state_reg == SCAN_IDLE && !stop_req && (dev_launch || host_launch))
		|| (state_reg == SCAN_WAIT && !stop_req && delay_over && touched);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			div_reg <= 32'd0;
			ms_left_reg <= 7'd0;
		end else if (launch) begin
			div_reg <= 32'd0;
			ms_left_reg <= batch_ms(batch_delay_select);
		end else if (!delay_over) begin
			if (div_reg == 32'(MS_CYCLES_P - 1)) begin
				div_reg <= 32'd0;
				ms_left_reg <= ms_left_reg - 7'd1;
			end else begin
				div_reg <= div_reg + 32'd1;
			end
		end
	end

	// ---------------------------------------------------------------
	// scan scheduler
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg <= SCAN_IDLE;
			scan_start <= 1'b0;
			scan_active <= 1'b0;
		end else begin
			scan_start <= launch;
			if (stop_req) begin
				state_reg <= SCAN_IDLE;
			end else begin
				case (state_reg)
					SCAN_IDLE: begin
						if (launch) begin
							state_reg <= SCAN_RUN;
						end
					end
					SCAN_RUN: begin
						// set end may be past delay
						if (set_done) begin
							state_reg <= SCAN_WAIT;
						end
					end
					SCAN_WAIT: begin
						if (launch) begin
							state_reg <= SCAN_RUN;
						end else if (delay_over || !touched) begin
							state_reg <= SCAN_IDLE;
						end
					end
					default: state_reg <= SCAN_IDLE;
				endcase
			end
			scan_active <= (state_reg != SCAN_IDLE) && !stop_req;
		end
	end

	// ---------------------------------------------------------------
	// zone detection and data flags
	// ---------------------------------------------------------------
	// results arrive already averaged
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			aux_data_reg <= DATA_RESET;
			temp_data_reg <= DATA_RESET;
		end else begin
			if (aux_valid && zone_ok(prep_cfg_reg[AUX_ZONE_LSB +: 2], aux_result, thr_low_reg, thr_high_reg)) begin
				aux_data_reg <= aux_result;
			end
			if (temp_valid && zone_ok(prep_cfg_reg[TEMP_ZONE_LSB +: 2], temp_result, thr_low_reg, thr_high_reg)) begin
				temp_data_reg <= temp_result;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			aux_avail_reg <= 1'b0;
			temp_avail_reg <= 1'b0;
		end else begin
			if (aux_valid && zone_ok(prep_cfg_reg[AUX_ZONE_LSB +: 2], aux_result, thr_low_reg, thr_high_reg)) begin
				aux_avail_reg <= 1'b1;
			end else if (rd_done && paddr == ADDR_AUX_DATA) begin
				aux_avail_reg <= 1'b0;
			end
			if (temp_valid && zone_ok(prep_cfg_reg[TEMP_ZONE_LSB +: 2], temp_result, thr_low_reg, thr_high_reg)) begin
				temp_avail_reg <= 1'b1;
			end else if (rd_done && paddr == ADDR_TEMP_DATA) begin
				temp_avail_reg <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// interrupt pin
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			touch_or_data_irq_pin <= 1'b1;
		end else begin
			case (prep_cfg_reg[PIN_SEL_LSB +: 2])
				2'h0: touch_or_data_irq_pin <= pen_sync_n_reg && dav_any;
				2'h2: touch_or_data_irq_pin <= pen_sync_n_reg;
				default: touch_or_data_irq_pin <= !dav_any;
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== sim/scan_cfg_monitor.sv
// port checker for the scan scheduler and config registers
`timescale 1ns/1ns
`default_nettype none
module scan_cfg_monitor
	import touch_cfg_pkg::*;
#(
	parameter int MS_CYCLES_P = 10
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pen_touch_n,
	input wire logic scan_start,
	input wire logic scan_active,
	input wire logic [3:0] panel_test_mode,
	input wire logic [2:0] batch_delay_select
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic acc;
	logic scan_wr;
	assign acc = psel && penable && pready;
	assign scan_wr = acc && pwrite && paddr == ADDR_SCAN_CFG;
	property p_ready; psel && penable && !pready |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("access phase not answered");
	property p_hold; !scan_wr |=> $stable({panel_test_mode, batch_delay_select}); endproperty
	a_hold: assert property (p_hold) else $error("scan fields moved without a write");
	property p_wr; scan_wr |=> panel_test_mode == $past(pwdata[11:8]) && batch_delay_select == $past(pwdata[2:0]);
	endproperty
	a_wr: assert property (p_wr) else $error("scan fields not taken from write");
	property p_rd; acc && !pwrite && paddr == ADDR_SCAN_CFG |-> prdata == {20'h0, panel_test_mode, 5'h0,
		batch_delay_select}; endproperty
	a_rd: assert property (p_rd) else $error("scan config readback wrong");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("error answer malformed");
	property p_launch; scan_start |=> scan_active; endproperty
	a_launch: assert property (p_launch) else $error("launch without active");
	property p_rise; $rose(scan_active) |-> $past(scan_start); endproperty
	a_rise: assert property (p_rise) else $error("active without launch");
	property p_idle; pen_touch_n [*5] |=> !scan_start; endproperty
	a_idle: assert property (p_idle) else $error("launch with pen lifted");
endmodule
bind touch_scan_cfg scan_cfg_monitor #(.MS_CYCLES_P(MS_CYCLES_P)) u_mon (.clk_sys(clk_sys), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pen_touch_n(pen_touch_n), .scan_start(scan_start),
	.scan_active(scan_active), .panel_test_mode(panel_test_mode), .batch_delay_select(batch_delay_select));
`default_nettype wire

// ===== sim/seq_model.sv
// sample-set sequencer stand-in, answers each launch after lat cycles
`timescale 1ns/1ns
`default_nettype none
module seq_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic scan_start,
	input wire logic [7:0] lat,
	output logic set_done
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt_reg <= 8'h00;
			set_done <= 1'b0;
		end else begin
			set_done <= cnt_reg == 8'h01;
			if (scan_start)
				cnt_reg <= lat;
			else if (cnt_reg != 8'h00)
				cnt_reg <= cnt_reg - 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the scan scheduler and config registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import touch_cfg_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_s;
	localparam int MS = 10;
	logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, ap, tp;
	logic pen_touch_n = 1'b1, filter_busy = 1'b0, aux_valid = 1'b0, temp_valid = 1'b0;
	logic pready, pslverr, set_done, scan_start, scan_active, irq_pin;
	logic [7:0] paddr = 8'h00, lat = 8'h03;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [11:0] aux_result = 12'h0, temp_result = 12'h0, pa = 12'h0, pt = 12'h0;
	logic [3:0] panel_test_mode;
	logic [2:0] batch_delay_select;
	logic [1:0] filter_sample_count, filter_window;
	logic [4:0] avg_filter_enable;
	int num_errors = 0, n_tests = 0, cyc = 0, g, lo, code;
	int ms[8] = '{0, 1, 2, 4, 10, 20, 40, 100};
	row_s rows[5] = '{'{ADDR_SCAN_CFG, 32'hffffffff, 32'h0f07, 1'b0}, '{ADDR_PREP_CFG, 32'hffffffff, 32'hffdf, 1'b0},
		'{ADDR_THR_LOW, 32'h100, 32'h100, 1'b0}, '{ADDR_THR_HIGH, 32'h200, 32'h200, 1'b0}, '{8'h20, 32'h5, 32'h0, 1'b1}};
	touch_scan_cfg #(.MS_CYCLES_P(MS)) dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pen_touch_n(pen_touch_n), .set_done(set_done), .filter_busy(filter_busy), .aux_valid(aux_valid),
		.aux_result(aux_result), .temp_valid(temp_valid), .temp_result(temp_result), .scan_start(scan_start),
		.scan_active(scan_active), .touch_or_data_irq_pin(irq_pin), .panel_test_mode(panel_test_mode),
		.batch_delay_select(batch_delay_select), .filter_sample_count(filter_sample_count),
		.filter_window(filter_window), .avg_filter_enable(avg_filter_enable));
	seq_model u_seq (.clk_sys(clk_sys), .rstn(rstn), .scan_start(scan_start), .lat(lat), .set_done(set_done));
	always #5 clk_sys = ~clk_sys;
	task final_report;
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// pready ends this wait; only the bench timeout ends a hang
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// cycles from one launch to the next
	task gap(output int n);
		int k;
		k = 0;
		while (scan_start !== 1'b1 && k < 3000) begin
			@(posedge clk_sys);
			k++;
		end
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (scan_start !== 1'b1 && n < 3000);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk({31'h0, er}, {31'h0, rows[i].e});
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].x);
		end
		chk({23'h0, filter_sample_count, filter_window, avg_filter_enable}, 32'h1ff);
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, ADDR_SCAN_CFG, {20'h0, c[3:0], 5'h0, c[2:0]});
			@(posedge clk_sys);
			chk({20'h0, panel_test_mode, 5'h0, batch_delay_select}, {20'h0, c[3:0], 5'h0, c[2:0]});
		end
		for (int z = 0; z < 4; z++) begin
			apb(1'b1, ADDR_PREP_CFG, 32'((z[0] ? 16'hc000 : 16'h4000) | (z << 8) | (z << 6)));
			aux_valid <= 1'b1;
			temp_valid <= 1'b1;
			aux_result <= 12'h150 + 12'(z);
			temp_result <= 12'h250 + 12'(z);
			@(posedge clk_sys);
			aux_valid <= 1'b0;
			temp_valid <= 1'b0;
			ap = z == 0 || z == 2;
			tp = z == 0 || z == 3;
			repeat (3) @(posedge clk_sys);
			chk({31'h0, irq_pin}, {31'h0, !(ap || tp)});
			filter_busy <= z == 0;
			apb(1'b0, ADDR_STATUS, 32'h0);
			filter_busy <= 1'b0;
			chk(rd, (z == 0) ? 32'h0 : {28'h0, 2'b01, tp, ap});
			if (ap)
				pa = 12'h150 + 12'(z);
			if (tp)
				pt = 12'h250 + 12'(z);
			apb(1'b0, ADDR_AUX_DATA, 32'h0);
			chk(rd, {20'h0, pa});
			apb(1'b0, ADDR_TEMP_DATA, 32'h0);
			chk(rd, {20'h0, pt});
		end
		apb(1'b1, ADDR_PREP_CFG, 32'h8000);
		pen_touch_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk({31'h0, irq_pin}, 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk({31'h0, rd[15]}, 32'h1);
		// last pass: set time longer than the delay
		for (int b = 0; b < 9; b++) begin
			code = (b == 8) ? 1 : b;
			lat <= (b == 8) ? 8'h3c : 8'h03;
			apb(1'b1, ADDR_SCAN_CFG, 32'(code));
			apb(1'b1, ADDR_CTRL, code[0] ? 32'h0001 : 32'h8000);
			gap(g);
			lo = (ms[code] * MS > lat) ? ms[code] * MS : lat;
			chk({31'h0, g >= lo && g <= lo + 4}, 32'h1);
			apb(1'b1, ADDR_CTRL, 32'h4000);
			repeat (3) @(posedge clk_sys);
			chk({31'h0, scan_active}, 32'h0);
		end
		// short sets again so the scheduler reaches the wait phase soon after the release, which lands in the run phase
		lat <= 8'h03;
		apb(1'b1, ADDR_CTRL, 32'h8000);
		gap(g);
		pen_touch_n <= 1'b1;
		repeat (30) @(posedge clk_sys);
		chk({30'h0, scan_active, irq_pin}, 32'h1);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		chk({14'h0, panel_test_mode, batch_delay_select, filter_sample_count, filter_window, avg_filter_enable,
			scan_active, irq_pin}, 32'h1);
		apb(1'b0, ADDR_PREP_CFG, 32'h0);
		chk(rd, 32'h0);
		// pin select 00: pen level and data flag combined
		chk({31'h0, irq_pin}, 32'h0);
		aux_valid <= 1'b1;
		aux_result <= 12'h0aa;
		@(posedge clk_sys);
		aux_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({31'h0, irq_pin}, 32'h1);
		apb(1'b0, ADDR_AUX_DATA, 32'h0);
		chk(rd, 32'h0000_00aa);
		final_report();
	end
endmodule
`default_nettype wire
